// file: core/att_timer_core.sv
// Timer core with I/O-clock or crystal-clock operation and holding registers that write through on the I/O clock and transfer after two crystal edges
`timescale 1ns/1ns
module att_timer_core
    import att_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Register port
    input wire att_bus_req_t bus_req,
    output logic [7:0] rdata,
    // Processor side
    input wire att_cpu_ctl_t cpu_ctl,
    output att_irq_t irq,
    output logic wake_req,
    output logic cpu_stall,
    // Oscillator pins
    input wire logic timer_osc_in,
    output logic osc_enable,
    output logic osc_pins_claimed
);
    logic [1:0] osc_sync_r;
    logic osc_prev_r;
    logic osc_rise;
    logic async_r;
    logic src_tick;
    logic [7:0] hold_r [3];
    logic [2:0] busy_r;
    logic [1:0] edge_cnt_r [3];
    logic [2:0] wr_sel;
    logic [2:0] load;
    logic [7:0] load_val [3];
    logic [7:0] cnt_r;
    logic [7:0] cmp_r;
    logic [7:0] ctl_r;
    logic [7:0] cnt_rd_r;
    logic [7:0] mask_r;
    logic [7:0] flags_r;
    logic psr_r;
    logic [9:0] presc_r;
    logic count_tick;
    logic dir_down_r;
    logic block_match_r;
    logic cmp_ev;
    logic ovf_ev;
    logic [1:0] pend_r;
    logic [1:0] pipe_r [FLAG_SYNC_CYCLES];
    logic [1:0] flag_set;
    logic irq_cond;
    att_wake_t wake_r;
    logic [2:0] stall_cnt_r;
    logic [7:0] rdata_r;

    // Divider tap select
    function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] p);
        logic hit;
        hit = 1'b0;
        unique case (cs)
            3'h0: hit = 1'b0;
            3'h1: hit = 1'b1;
            3'h2: hit = &p[2:0];
            3'h3: hit = &p[4:0];
            3'h4: hit = &p[5:0];
            3'h5: hit = &p[6:0];
            3'h6: hit = &p[7:0];
            3'h7: hit = &p[9:0];
        endcase
        return hit;
    endfunction

    // Oscillator pin is asynchronous; edges found after two flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            osc_sync_r <= 2'h0;
            osc_prev_r <= 1'b0;
        end else begin
            osc_sync_r <= {osc_sync_r[0], timer_osc_in};
            osc_prev_r <= osc_sync_r[1];
        end
    end
    assign osc_rise = osc_sync_r[1] & ~osc_prev_r;

    assign src_tick = async_r ? osc_rise : 1'b1;
    assign osc_pins_claimed = async_r;
    assign osc_enable = async_r & ~cpu_ctl.sleep_deep;

    assign wr_sel[HR_CTL] = bus_req.wr && bus_req.addr == OFS_CONTROL;
    assign wr_sel[HR_CMP] = bus_req.wr && bus_req.addr == OFS_COMPARE;
    assign wr_sel[HR_CNT] = bus_req.wr && bus_req.addr == OFS_COUNT;

    for (genvar i = 0; i < 3; i++) begin : g_hold
        assign load[i] = (wr_sel[i] & ~async_r)
            | (busy_r[i] & osc_rise & edge_cnt_r[i] == XFER_EDGES - 2'h1);
        assign load_val[i] = async_r ? hold_r[i] : bus_req.wdata;
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                hold_r[i] <= RST_REG;
                busy_r[i] <= 1'b0;
                edge_cnt_r[i] <= 2'h0;
            end else if (wr_sel[i]) begin
                // busy set on write in asynchronous mode, wins over transfer
                hold_r[i] <= bus_req.wdata;
                busy_r[i] <= async_r;
                edge_cnt_r[i] <= 2'h0;
            end else if (busy_r[i] && osc_rise) begin
                edge_cnt_r[i] <= edge_cnt_r[i] + 2'h1;
                if (load[i]) begin
                    busy_r[i] <= 1'b0;
                end
            end
        end
    end

    // Compare and control destinations
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmp_r <= RST_REG;
            ctl_r <= RST_REG;
        end else begin
            if (load[HR_CMP]) begin
                cmp_r <= load_val[HR_CMP];
            end
            if (load[HR_CTL]) begin
                ctl_r <= load_val[HR_CTL];
            end
        end
    end

    // Status, mask and special-function registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            async_r <= 1'b0;
            mask_r <= RST_REG;
            psr_r <= 1'b0;
        end else begin
            if (bus_req.wr && bus_req.addr == OFS_STATUS) begin
                async_r <= bus_req.wdata[STAT_ASYNC_BIT];
            end
            if (bus_req.wr && bus_req.addr == OFS_MASK) begin
                mask_r <= bus_req.wdata;
            end
            // written one holds until the reset is done; zero ignored
            if (bus_req.wr && bus_req.addr == OFS_SPECIAL && bus_req.wdata[SPEC_PSR_BIT]) begin
                psr_r <= 1'b1;
            end else if (src_tick) begin
                psr_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            presc_r <= RST_PRESC;
        end else if (src_tick) begin
            presc_r <= psr_r ? RST_PRESC : presc_r + 10'h001;
        end
    end

    assign count_tick = src_tick & ~psr_r & tap_hit(ctl_r[CTL_CS_LSB +: 3], presc_r);

    assign cmp_ev = count_tick & cnt_r == cmp_r & ~block_match_r
        & ~busy_r[HR_CMP] & ~busy_r[HR_CNT];
    // overflow at top, or turn at bottom in phase-correct
    assign ovf_ev = count_tick & (ctl_r[CTL_WGM0_BIT] & ~ctl_r[CTL_WGM1_BIT]
        ? (dir_down_r & cnt_r == CNT_BOTTOM) : (cnt_r == CNT_MAX));

    // Counter; a load blocks the match on the next timer clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= RST_REG;
            dir_down_r <= 1'b0;
            block_match_r <= 1'b0;
        end else if (load[HR_CNT]) begin
            cnt_r <= load_val[HR_CNT];
            block_match_r <= 1'b1;
        end else if (count_tick) begin
            block_match_r <= 1'b0;
            if (ctl_r[CTL_WGM0_BIT] & ~ctl_r[CTL_WGM1_BIT]) begin
                if (!dir_down_r && cnt_r == CNT_MAX) begin
                    dir_down_r <= 1'b1;
                    cnt_r <= cnt_r - 8'h01;
                end else if (dir_down_r && cnt_r == CNT_BOTTOM) begin
                    dir_down_r <= 1'b0;
                    cnt_r <= cnt_r + 8'h01;
                end else begin
                    cnt_r <= dir_down_r ? cnt_r - 8'h01 : cnt_r + 8'h01;
                end
            end else if (ctl_r[CTL_WGM1_BIT] & ~ctl_r[CTL_WGM0_BIT] && cnt_r == cmp_r) begin
                cnt_r <= CNT_BOTTOM;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    // read copy frozen across power-save until the next edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_rd_r <= RST_REG;
        end else if (osc_rise && !cpu_ctl.sleep_save) begin
            cnt_rd_r <= cnt_r;
        end
    end

    // event waits one oscillator edge, then three processor cycles
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pend_r <= 2'h0;
            for (int k = 0; k < FLAG_SYNC_CYCLES; k++) begin
                pipe_r[k] <= 2'h0;
            end
        end else begin
            pend_r <= async_r ? ((osc_rise ? 2'h0 : pend_r) | {cmp_ev, ovf_ev}) : 2'h0;
            pipe_r[0] <= (async_r & osc_rise) ? pend_r : 2'h0;
            for (int k = 1; k < FLAG_SYNC_CYCLES; k++) begin
                pipe_r[k] <= pipe_r[k - 1];
            end
        end
    end
    assign flag_set = async_r ? pipe_r[FLAG_SYNC_CYCLES - 1] : {cmp_ev, ovf_ev};

    // flags; a set in the clearing cycle wins
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flags_r <= RST_REG;
        end else begin
            if (flag_set[1]) begin
                flags_r[FLAG_CMP_BIT] <= 1'b1;
            end else if (cpu_ctl.cmp_vec_ack
                || (bus_req.wr && bus_req.addr == OFS_FLAGS && bus_req.wdata[FLAG_CMP_BIT])) begin
                flags_r[FLAG_CMP_BIT] <= 1'b0;
            end
            if (flag_set[0]) begin
                flags_r[FLAG_OVF_BIT] <= 1'b1;
            end else if (cpu_ctl.ovf_vec_ack
                || (bus_req.wr && bus_req.addr == OFS_FLAGS && bus_req.wdata[FLAG_OVF_BIT])) begin
                flags_r[FLAG_OVF_BIT] <= 1'b0;
            end
        end
    end

    assign irq.cmp_req = cpu_ctl.gie & mask_r[MASK_CMP_IE_BIT] & flags_r[FLAG_CMP_BIT];
    assign irq.ovf_req = cpu_ctl.gie & mask_r[MASK_OVF_IE_BIT] & flags_r[FLAG_OVF_BIT];
    assign irq_cond = irq.cmp_req | irq.ovf_req;

    // Wake sequence
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wake_r <= WK_RUN;
            stall_cnt_r <= 3'h0;
        end else begin
            unique case (wake_r)
                WK_RUN: begin
                    if (cpu_ctl.sleep_save && irq_cond) begin
                        wake_r <= WK_PEND;
                    end
                end
                WK_PEND: begin
                    if (src_tick) begin
                        wake_r <= WK_STALL;
                        stall_cnt_r <= 3'h0;
                    end
                end
                WK_STALL: begin
                    stall_cnt_r <= stall_cnt_r + 3'h1;
                    if (stall_cnt_r == STALL_CYCLES - 3'h1) begin
                        wake_r <= WK_REARM;
                    end
                end
                WK_REARM: begin
                    if (src_tick) begin
                        wake_r <= WK_RUN;
                    end
                end
            endcase
        end
    end
    assign cpu_stall = wake_r == WK_STALL;
    assign wake_req = wake_r == WK_PEND && src_tick;

    // read paths; data stands one cycle after the strobe
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= RST_REG;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_COUNT: rdata_r <= async_r ? cnt_rd_r : cnt_r;
                OFS_COMPARE: rdata_r <= hold_r[HR_CMP];
                OFS_CONTROL: rdata_r <= hold_r[HR_CTL] & ~(8'h01 << CTL_FORCE_BIT);
                OFS_STATUS: rdata_r <= {4'h0, async_r, busy_r[HR_CNT], busy_r[HR_CMP],
                    busy_r[HR_CTL]};
                OFS_MASK: rdata_r <= mask_r;
                OFS_FLAGS: rdata_r <= flags_r;
                OFS_SPECIAL: rdata_r <= {6'h00, psr_r, 1'b0};
                default: rdata_r <= RST_REG;
            endcase
        end else begin
            rdata_r <= RST_REG;
        end
    end
    assign rdata = rdata_r;

    property p_cmp_busy_set;
        @(posedge mclk) disable iff (!arst_n)
        (async_r && wr_sel[HR_CMP]) |=> busy_r[HR_CMP];
    endproperty
    a_cmp_busy_set: assert property (p_cmp_busy_set) else $error("compare busy not set");

    property p_ctl_sync_nobusy;
        @(posedge mclk) disable iff (!arst_n)
        (!async_r && wr_sel[HR_CTL]) |=> !busy_r[HR_CTL] && ctl_r == $past(bus_req.wdata);
    endproperty
    a_ctl_sync_nobusy: assert property (p_ctl_sync_nobusy) else $error("control sync load bad");

    property p_cnt_two_edges;
        @(posedge mclk) disable iff (!arst_n)
        $fell(busy_r[HR_CNT]) |-> $past(osc_rise) && $past(edge_cnt_r[HR_CNT]) == 2'h1;
    endproperty
    a_cnt_two_edges: assert property (p_cnt_two_edges) else $error("counter latched early");

    property p_cmp_readback;
        @(posedge mclk) disable iff (!arst_n)
        (bus_req.rd && bus_req.addr == OFS_COMPARE) |=> rdata == $past(hold_r[HR_CMP]);
    endproperty
    a_cmp_readback: assert property (p_cmp_readback) else $error("compare readback wrong");

    property p_inhibit;
        @(posedge mclk) disable iff (!arst_n)
        (busy_r[HR_CMP] || busy_r[HR_CNT]) |-> !cmp_ev;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("match while write pending");

    property p_stall_four;
        @(posedge mclk) disable iff (!arst_n)
        $rose(cpu_stall) |-> cpu_stall[*4] ##1 !cpu_stall;
    endproperty
    a_stall_four: assert property (p_stall_four) else $error("stall length wrong");

    property p_cmp_req_gate;
        @(posedge mclk) disable iff (!arst_n)
        irq.cmp_req |-> cpu_ctl.gie && mask_r[MASK_CMP_IE_BIT] && flags_r[FLAG_CMP_BIT];
    endproperty
    a_cmp_req_gate: assert property (p_cmp_req_gate) else $error("compare request ungated");

    property p_ovf_clear;
        @(posedge mclk) disable iff (!arst_n)
        (cpu_ctl.ovf_vec_ack && !flag_set[0]) |=> !flags_r[FLAG_OVF_BIT];
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");
endmodule // att_timer_core

// file: shared/att_pkg.sv
// Constants and carrier types for the asynchronous-capable 8-bit timer
package att_pkg;
    // Register offsets
    localparam logic [2:0] OFS_COUNT = 3'h0;
    localparam logic [2:0] OFS_COMPARE = 3'h1;
    localparam logic [2:0] OFS_CONTROL = 3'h2;
    localparam logic [2:0] OFS_STATUS = 3'h3;
    localparam logic [2:0] OFS_MASK = 3'h4;
    localparam logic [2:0] OFS_FLAGS = 3'h5;
    localparam logic [2:0] OFS_SPECIAL = 3'h6;
    // Control fields
    localparam int CTL_FORCE_BIT = 7;
    localparam int CTL_WGM0_BIT = 6;
    localparam int CTL_WGM1_BIT = 3;
    localparam int CTL_CS_LSB = 0;
    // Status fields
    localparam int STAT_ASYNC_BIT = 3;
    localparam int STAT_CNT_UB_BIT = 2;
    localparam int STAT_CMP_UB_BIT = 1;
    localparam int STAT_CTL_UB_BIT = 0;
    // Mask, flag and special-function fields
    localparam int MASK_CMP_IE_BIT = 7;
    localparam int MASK_OVF_IE_BIT = 6;
    localparam int FLAG_CMP_BIT = 7;
    localparam int FLAG_OVF_BIT = 6;
    localparam int SPEC_PSR_BIT = 1;
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [9:0] RST_PRESC = 10'h000;
    // Holding register index
    localparam int HR_CTL = 0;
    localparam int HR_CMP = 1;
    localparam int HR_CNT = 2;
    // Timing counts
    localparam logic [1:0] XFER_EDGES = 2'h2;
    localparam logic [2:0] STALL_CYCLES = 3'h4;
    localparam int FLAG_SYNC_CYCLES = 3;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } att_bus_req_t;

    typedef struct packed {
        logic gie;
        logic cmp_vec_ack;
        logic ovf_vec_ack;
        logic sleep_save;
        logic sleep_deep;
    } att_cpu_ctl_t;

    typedef struct packed {
        logic cmp_req;
        logic ovf_req;
    } att_irq_t;

    typedef enum logic [1:0] {
        WK_RUN = 2'b00,
        WK_PEND = 2'b01,
        WK_STALL = 2'b11,
        WK_REARM = 2'b10
    } att_wake_t;
endpackage

// file: testbench/att_osc_model.sv
// Crystal oscillator model feeding the timer's oscillator pin
`timescale 1ns/1ns
module att_osc_model #(
    parameter int HALF_NS = 19
) (
    // Enable from the core
    input wire logic osc_enable,
    // Oscillator pin
    output logic timer_osc_in
);
    // Free-running phase, unrelated to mclk, so sync hazards are exercised
    initial begin
        timer_osc_in = 1'b0;
        forever begin
            #HALF_NS;
            timer_osc_in = osc_enable ? ~timer_osc_in : 1'b0;
        end
    end
endmodule // att_osc_model

// file: testbench/att_timer_core_tb.sv
// Self-checking bench for the timer core and its crystal model
`timescale 1ns/1ns
module att_timer_core_tb;
    import att_pkg::*;
    logic mclk;
    logic arst_n;
    att_bus_req_t bus_req;
    logic [7:0] rdata;
    att_cpu_ctl_t cpu_ctl;
    att_irq_t irq;
    logic wake_req, cpu_stall, timer_osc_in, osc_enable, osc_pins_claimed;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int stl = 0;
    logic rd_seen = 1'b0;
    logic [7:0] rd_val;
    logic [15:0] lohi;
    logic [31:0] seed = 32'h00008499;
    logic [15:0] rd_q[$];
    int stall_q[$];

    att_timer_core i_dut (.mclk(mclk), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
        .cpu_ctl(cpu_ctl), .irq(irq), .wake_req(wake_req), .cpu_stall(cpu_stall),
        .timer_osc_in(timer_osc_in), .osc_enable(osc_enable),
        .osc_pins_claimed(osc_pins_claimed));
    att_osc_model #(.HALF_NS(19)) i_osc (.osc_enable(osc_enable), .timer_osc_in(timer_osc_in));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic end_of_test();
        $display("checked %0d, failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [7:0] lo, input logic [7:0] hi);
        checked++;
        if ($isunknown(rdata) || rdata < lo || rdata > hi) begin
            n_fail++;
            $display("mismatch at %0t: read %h not in %h..%h", $time, rdata, lo, hi);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: level %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_len(input int got, input int exp);
        checked++;
        if (got != exp) begin
            n_fail++;
            $display("mismatch at %0t: length %0d, expected %0d", $time, got, exp);
        end
    endtask

    // Watcher: read results, stall length and the run limit
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("mismatch at %0t: run limit reached", $time);
            end_of_test();
        end
        if (rd_seen) begin
            rd_val = rdata;
            lohi = rd_q.pop_front();
            chk_rd(lohi[15:8], lohi[7:0]);
        end
        rd_seen = bus_req.rd;
        if (cpu_stall === 1'b1) begin
            stl++;
        end else if (stl > 0) begin
            chk_len(stl, (stall_q.size() > 0) ? stall_q.pop_front() : 0);
            stl = 0;
        end
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus_req <= '{a, d, 1'b0, 1'b0};
        @(posedge mclk);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi,
        output logic [7:0] v);
        rd_q.push_back({lo, hi});
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b0};
        @(posedge mclk);
        #1;
        v = rd_val;
    endtask

    task automatic ex(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, e, e, v);
    endtask

    // Polls status until all three transfers have landed
    task automatic wait_idle();
        logic [7:0] v;
        int n;
        n = 0;
        v = 8'hff;
        while (v[2:0] !== 3'h0 && n < 40) begin
            rd(OFS_STATUS, 8'h00, 8'hff, v);
            n++;
        end
        chk_bit(v[2:0] === 3'h0, 1'b1);
    endtask

    initial begin
        logic [7:0] d;
        logic [7:0] v;
        int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
        int n;
        arst_n = 1'b0;
        bus_req = '0;
        cpu_ctl = '0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        #1;
        for (int a = 0; a < 8; a++) begin
            ex(a[2:0], 8'h00);
        end
        chk_bit(osc_pins_claimed, 1'b0);
        $display("test reset done");

        d = rnd();
        wr(OFS_COMPARE, d);
        ex(OFS_COMPARE, d);
        ex(OFS_STATUS, 8'h00);
        wr(OFS_SPECIAL, 8'h02);
        ex(OFS_SPECIAL, 8'h00);
        for (int cs = 0; cs < 8; cs++) begin
            wr(OFS_CONTROL, 8'h00);
            wr(OFS_COUNT, 8'h00);
            wr(OFS_SPECIAL, 8'h02);
            wr(OFS_CONTROL, cs[7:0]);
            repeat (divs[cs] * 6) @(posedge mclk);
            rd(OFS_COUNT, (cs == 0) ? 8'h00 : 8'h05,
                (cs == 0) ? 8'h00 : (cs == 1) ? 8'h0a : 8'h07, v);
        end
        $display("test prescaler done");

        wr(OFS_MASK, 8'hc0);
        ex(OFS_MASK, 8'hc0);
        wr(OFS_COUNT, 8'hf0);
        wr(OFS_COMPARE, 8'hf8);
        wr(OFS_FLAGS, 8'hc0);
        cpu_ctl.gie <= 1'b1;
        wr(OFS_CONTROL, 8'h01);
        repeat (30) @(posedge mclk);
        #1;
        chk_bit(irq.cmp_req, 1'b1);
        chk_bit(irq.ovf_req, 1'b1);
        ex(OFS_FLAGS, 8'hc0);
        cpu_ctl.gie <= 1'b0;
        #1;
        chk_bit(irq.cmp_req | irq.ovf_req, 1'b0);
        cpu_ctl.gie <= 1'b1;
        wr(OFS_MASK, 8'h80);
        #1;
        chk_bit(irq.ovf_req, 1'b0);
        wr(OFS_FLAGS, 8'h40);
        ex(OFS_FLAGS, 8'h80);
        wr(OFS_CONTROL, 8'h00);
        $display("test flags done");

        wr(OFS_MASK, 8'h00);
        wr(OFS_STATUS, 8'h08);
        #1;
        chk_bit(osc_pins_claimed, 1'b1);
        chk_bit(osc_enable, 1'b1);
        d = rnd();
        wr(OFS_COMPARE, d);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_CONTROL, 8'h00);
        ex(OFS_STATUS, 8'h0f);
        ex(OFS_COMPARE, d);
        wait_idle();
        ex(OFS_COMPARE, d);
        $display("test async writes done");

        wr(OFS_COMPARE, 8'h20);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_CONTROL, 8'h01);
        wait_idle();
        wr(OFS_FLAGS, 8'hc0);
        wr(OFS_MASK, 8'h80);
        stall_q.push_back(4);
        cpu_ctl.sleep_save <= 1'b1;
        n = 0;
        while (wake_req !== 1'b1 && n < 800) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk_bit(wake_req, 1'b1);
        cpu_ctl.sleep_save <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        ex(OFS_FLAGS, 8'h80);
        chk_bit(irq.cmp_req, 1'b1);
        cpu_ctl.cmp_vec_ack <= 1'b1;
        @(posedge mclk);
        cpu_ctl.cmp_vec_ack <= 1'b0;
        #1;
        ex(OFS_FLAGS, 8'h00);
        wr(OFS_CONTROL, 8'h01);
        wait_idle();
        rd(OFS_COUNT, 8'h21, 8'h60, v);
        $display("test wake done");

        cpu_ctl.sleep_deep <= 1'b1;
        @(posedge mclk);
        #1;
        chk_bit(osc_enable, 1'b0);
        cpu_ctl.sleep_deep <= 1'b0;
        @(posedge mclk);
        #1;
        chk_bit(osc_enable, 1'b1);
        chk_len(stall_q.size(), 0);
        $display("test deep sleep done");
        end_of_test();
    end
endmodule // att_timer_core_tb
